//--- sbsc_core.sv
`timescale 1ns/1ps
module sbsc_core
    import sbsc_pkg::*;
#(
    parameter bit WIDE_ORG = 1'h1 // 1: four lanes, 0: lanes a and b only
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire sbsc_mode_t MODE_PINS_I,
    input wire sbsc_bus_t BUS_CTRL_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic OUT_EN_N_I,
    input wire logic [DATA_W-1:0] DQ_I,
    output logic [DATA_W-1:0] DQ_O,
    output logic [LANES-1:0] DQ_OE_O,
    output logic [ADDR_W-1:0] ARRAY_ADDR_O,
    output logic [LANES-1:0] ARRAY_WE_O,
    output logic [DATA_W-1:0] ARRAY_WDATA_O,
    input wire logic [DATA_W-1:0] ARRAY_RDATA_I,
    output logic STANDBY_O,
    output logic DRIVE_HIGH_O
);

    // mode pin synchroniser, three stages plus agreed value
    sbsc_mode_t meta_r, meta_nxt; // first stage, read by second only
    sbsc_mode_t s2_r, s2_nxt;
    sbsc_mode_t s3_r, s3_nxt;
    sbsc_mode_t mode_r, mode_nxt; // accepted mode setting

    // access state
    sbsc_cyc_t cyc_r, cyc_nxt;        // type of last captured cycle
    logic [ADDR_W-1:LOW_W] hi_r, hi_nxt; // upper word address
    logic [LOW_W-1:0] preset_r, preset_nxt; // burst start address
    logic [LOW_W-1:0] step_r, step_nxt;     // burst step index
    logic [LANES-1:0] we_r, we_nxt;         // array lane strobes
    logic [DATA_W-1:0] wdata_r, wdata_nxt;  // captured write data

    // output stage
    logic rd_s2_r, rd_s2_nxt;   // pipelined read slot valid
    logic hold_r, hold_nxt;     // dual deselect extra drive cycle
    logic [DATA_W-1:0] dout_r, dout_nxt; // output data register

    // decoded controls
    logic interleave; // burst order
    logic pipe_mode;  // output register in use
    logic scd_mode;   // single cycle deselect
    logic sleep;      // standby
    logic ce;         // chip selected
    logic proc_start; // processor strobe start
    logic ctrl_start; // controller strobe start
    logic start;      // new external address
    logic desel_req;  // deselect this edge
    logic busy;       // burst in progress
    logic hold_req;   // continue or suspend
    logic adv_go;     // counter steps this edge
    logic wr_req;     // write requested
    logic [LANES-1:0] wr_lanes; // lanes to write
    logic drive;      // outputs allowed by the cycle pipeline

    // synchroniser next values
    always_comb begin
        meta_nxt = MODE_PINS_I;
        s2_nxt = meta_r;
        s3_nxt = s2_r;
        mode_nxt = mode_r;
        // a change counts once stages two and three agree
        if (s2_r == s3_r) begin
            mode_nxt = s3_r;
        end
    end

    // synchroniser registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            meta_r <= MODE_DEFAULT;
            s2_r <= MODE_DEFAULT;
            s3_r <= MODE_DEFAULT;
            mode_r <= MODE_DEFAULT;
        end else begin
            meta_r <= meta_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            mode_r <= mode_nxt;
        end
    end

    // mode and bus decode
    always_comb begin
        scd_mode = mode_r.deselect_mode_sel;
        interleave = mode_r.burst_order_sel_n;
        pipe_mode = mode_r.flow_through_sel_n;
        sleep = mode_r.sleep_req;
        ce = ~BUS_CTRL_I.chip_select_n;
        proc_start = ce & ~BUS_CTRL_I.proc_addr_strobe_n;
        ctrl_start = ce & ~BUS_CTRL_I.ctrl_addr_strobe_n & BUS_CTRL_I.proc_addr_strobe_n;
        start = (proc_start | ctrl_start) & ~sleep;
        desel_req = (~ce & ~BUS_CTRL_I.ctrl_addr_strobe_n) | sleep;
        busy = (cyc_r != CYC_DESEL);
        hold_req = ~start & ~desel_req & busy;
        adv_go = hold_req & ~BUS_CTRL_I.burst_advance_n;
        wr_req = ~BUS_CTRL_I.global_write_n | ~BUS_CTRL_I.byte_write_n;
        if (~BUS_CTRL_I.global_write_n) begin
            wr_lanes = LANES_ALL;
        end else if (~BUS_CTRL_I.byte_write_n) begin
            wr_lanes = ~BUS_CTRL_I.lane_write_en_n;
        end else begin
            wr_lanes = LANES_NONE;
        end
        wr_lanes = wr_lanes & lane_mask(WIDE_ORG);
    end

    // access next values
    always_comb begin
        cyc_nxt = cyc_r;
        hi_nxt = hi_r;
        preset_nxt = preset_r;
        step_nxt = step_r;
        case (cyc_r)
            CYC_DESEL: begin
                // only an external start leaves deselect
                if (start) begin
                    cyc_nxt = (proc_start | ~wr_req) ? CYC_READ : CYC_WRITE;
                end
            end
            CYC_READ, CYC_WRITE: begin
                // continue and suspend keep the burst
                cyc_nxt = wr_req ? CYC_WRITE : CYC_READ;
                if (start) begin
                    cyc_nxt = (proc_start | ~wr_req) ? CYC_READ : CYC_WRITE;
                end
            end
            default: begin
                cyc_nxt = CYC_DESEL;
            end
        endcase
        if (start) begin
            hi_nxt = ADDR_I[ADDR_W-1:LOW_W];
            preset_nxt = ADDR_I[LOW_W-1:0];
            step_nxt = STEP_FIRST;
        end else if (adv_go) begin
            step_nxt = LOW_W'(step_r + STEP_INC);
        end
        if (desel_req) begin
            cyc_nxt = CYC_DESEL;
        end
        // array strobes and data for a write cycle
        we_nxt = (cyc_nxt == CYC_WRITE) ? wr_lanes : LANES_NONE;
        wdata_nxt = (cyc_nxt == CYC_WRITE) ? DQ_I : wdata_r;
    end

    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cyc_r <= CYC_DESEL;
            hi_r <= '0;
            preset_r <= STEP_FIRST;
            step_r <= STEP_FIRST;
            we_r <= LANES_NONE;
            wdata_r <= '0;
        end else begin
            cyc_r <= cyc_nxt;
            hi_r <= hi_nxt;
            preset_r <= preset_nxt;
            step_r <= step_nxt;
            we_r <= we_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // output stage next values
    always_comb begin
        rd_s2_nxt = (cyc_r == CYC_READ);
        // in pipeline mode dual deselect holds the last read one more cycle
        hold_nxt = rd_s2_r & ~scd_mode & (cyc_r == CYC_DESEL);
        dout_nxt = (cyc_r == CYC_READ) ? ARRAY_RDATA_I : dout_r;
    end

    // output stage registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_s2_r <= 1'h0;
            hold_r <= 1'h0;
            dout_r <= '0;
        end else begin
            rd_s2_r <= rd_s2_nxt;
            hold_r <= hold_nxt;
            dout_r <= dout_nxt;
        end
    end

    // driver enable and data select
    always_comb begin
        if (sleep) begin
            drive = 1'h0;
        end else if (pipe_mode) begin
            drive = (rd_s2_r | hold_r) & (cyc_r != CYC_WRITE);
        end else begin
            drive = (cyc_r == CYC_READ);
        end
        DQ_OE_O = {LANES{drive & ~OUT_EN_N_I}} & lane_mask(WIDE_ORG);
        DQ_O = pipe_mode ? dout_r : ARRAY_RDATA_I;
        ARRAY_ADDR_O = {hi_r, burst_low(preset_r, step_r, interleave)};
        ARRAY_WE_O = we_r;
        ARRAY_WDATA_O = wdata_r;
        STANDBY_O = sleep;
        DRIVE_HIGH_O = ~mode_r.drive_strength_sel;
    end

    // checks on the burst counter
    chk_load_preset: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        start |=> ARRAY_ADDR_O == $past(ADDR_I))
        else $error("start did not load the external address");
    chk_linear_step: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        adv_go & ~interleave & $stable(interleave) |=>
        ARRAY_ADDR_O[LOW_W-1:0] == LOW_W'($past(ARRAY_ADDR_O[LOW_W-1:0]) + STEP_INC))
        else $error("linear burst did not add one");
    chk_interleave_step: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        adv_go & interleave |=> ARRAY_ADDR_O[LOW_W-1:0] == (preset_r ^ LOW_W'($past(step_r) + STEP_INC)))
        else $error("interleaved burst address wrong");
    chk_burst_wrap: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        start ##1 adv_go [*4] |=> ARRAY_ADDR_O[LOW_W-1:0] == $past(ADDR_I[LOW_W-1:0], 5))
        else $error("burst did not wrap to preset");
    chk_dummy_read: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        adv_go & OUT_EN_N_I |=> step_r == LOW_W'($past(step_r) + STEP_INC))
        else $error("dummy read did not advance");

    // checks on cycle decode
    chk_desel_block: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ~ce & ~BUS_CTRL_I.ctrl_addr_strobe_n |=> cyc_r == CYC_DESEL && ARRAY_WE_O == LANES_NONE)
        else $error("unselected strobe did not deselect");
    chk_global_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ctrl_start & ~sleep & ~BUS_CTRL_I.global_write_n |=> ARRAY_WE_O == lane_mask(WIDE_ORG))
        else $error("global write missed a lane");
    chk_byte_lanes: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ctrl_start & ~sleep & BUS_CTRL_I.global_write_n & ~BUS_CTRL_I.byte_write_n |=>
        ARRAY_WE_O == (~$past(BUS_CTRL_I.lane_write_en_n) & lane_mask(WIDE_ORG)))
        else $error("byte write lanes wrong");
    chk_read_no_we: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        cyc_r == CYC_READ |-> ARRAY_WE_O == LANES_NONE)
        else $error("read cycle strobed the array");

    // checks on the data pins
    chk_hiz_write: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        cyc_r == CYC_WRITE |-> DQ_OE_O == LANES_NONE)
        else $error("pins driven during write");
    chk_narrow_lanes: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        ~WIDE_ORG |-> ((DQ_OE_O | ARRAY_WE_O) & ~LANES_NARROW) == LANES_NONE)
        else $error("absent lane active");
    chk_oe_off: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        OUT_EN_N_I | sleep |-> DQ_OE_O == LANES_NONE)
        else $error("drivers on with output enable high");
    chk_pipe_latency: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        pipe_mode & $stable(pipe_mode) & cyc_r == CYC_READ |=> DQ_O == $past(ARRAY_RDATA_I))
        else $error("pipelined data not one clock later");
    chk_dual_hold: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        pipe_mode & ~scd_mode & rd_s2_r & cyc_r == CYC_DESEL & ~sleep ##1
        ~OUT_EN_N_I & ~sleep & cyc_r != CYC_WRITE
        |-> DQ_OE_O[0])
        else $error("dual deselect released drivers early");
    chk_single_off: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        pipe_mode & scd_mode & $stable(scd_mode) & cyc_r == CYC_DESEL |=> DQ_OE_O == LANES_NONE)
        else $error("single deselect kept drivers on");

endmodule // sbsc_core

//--- sbsc_pkg.sv
// shared constants and types of the burst sram control block
package sbsc_pkg;
    // organisation: four nine-bit byte lanes, 512k words
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int ADDR_W = 19;
    localparam int LOW_W = 2;
    // burst step start and increment
    localparam logic [LOW_W-1:0] STEP_FIRST = 2'h0;
    localparam logic [LOW_W-1:0] STEP_INC = 2'h1;
    // lane masks
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hf;
    localparam logic [LANES-1:0] LANES_NARROW = 4'h3;

    // static mode pins, one bit each
    typedef struct packed {
        logic burst_order_sel_n;  // low: linear, high: interleaved
        logic flow_through_sel_n; // low: flow-through, high: pipeline
        logic deselect_mode_sel;  // low: dual, high: single cycle deselect
        logic drive_strength_sel; // low: high drive
        logic sleep_req;          // high: standby
    } sbsc_mode_t;

    // levels the pad resistors give an open pin
    localparam sbsc_mode_t MODE_DEFAULT = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0};

    // synchronous bus controls, all active low
    typedef struct packed {
        logic chip_select_n;
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_n;
        logic [LANES-1:0] lane_write_en_n; // index 0..3 is lane a..d
    } sbsc_bus_t;

    // captured cycle type, gray along desel-read-write
    typedef enum logic [1:0] {
        CYC_DESEL = 2'h0,
        CYC_READ = 2'h1,
        CYC_WRITE = 2'h3
    } sbsc_cyc_t;

    // low word address from preset and step
    function automatic logic [LOW_W-1:0] burst_low(input logic [LOW_W-1:0] preset,
                                                   input logic [LOW_W-1:0] step,
                                                   input logic interleave);
        burst_low = interleave ? (preset ^ step) : LOW_W'(preset + step);
    endfunction

    // lanes that exist in the chosen organisation
    function automatic logic [LANES-1:0] lane_mask(input logic wide);
        lane_mask = wide ? LANES_ALL : LANES_NARROW;
    endfunction
endpackage

//--- sbsc_bus_model.sv
`timescale 1ns/1ps
// far-side bus controller: strobes, address and write data
module sbsc_bus_model
    import sbsc_pkg::*;
(
    input wire logic clk_i,
    output sbsc_bus_t bus_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o
);
    // idle bus is a deselect with no write pending
    initial begin
        bus_o = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'hf};
        addr_o = '0;
        data_o = '0;
    end

    // one bus cycle, launched just after a rising edge, held a full cycle
    // proc strobe high in bursts
    task automatic cyc(input sbsc_bus_t b, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        bus_o <= b;
        addr_o <= (b.proc_addr_strobe_n & b.ctrl_addr_strobe_n) ? ~addr_o : a;
        // released data lines toggle so stale data never matches
        data_o <= (b.global_write_n & b.byte_write_n) ? ~data_o : d;
        #1;
    endtask
endmodule // sbsc_bus_model

//--- test_sync_burst_sram_control.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); end end
module test_sync_burst_sram_control
    import sbsc_pkg::*;
;
    // common bus cycles: deselect, ctrl strobe read start, advance
    localparam sbsc_bus_t DESEL = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'hf};
    localparam sbsc_bus_t RD_C = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 4'h0};
    localparam sbsc_bus_t BURST_ADVANCE_N = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 4'hf};
    // lane enables for back-to-back writes
    localparam logic [LANES-1:0] LANE_TBL [8] = '{4'hf, 4'he, 4'hd, 4'hb, 4'h7, 4'h0, 4'hf, 4'ha};
    logic clk, rst, oe_n, standby, drive_high;
    sbsc_mode_t mode;
    sbsc_bus_t bus;
    logic [ADDR_W-1:0] addr, a_addr, n_addr;
    logic [DATA_W-1:0] dq_in, dq_out, wdata, rdata, n_rdata;
    logic [LANES-1:0] dq_oe, we, n_oe, n_we;
    int num_errors = 0;
    int tests_run = 0;

    // array contents are a pattern of the address
    function automatic logic [DATA_W-1:0] rd_pat(input logic [ADDR_W-1:0] a);
        rd_pat = {a[17:0], ~a[17:0]};
    endfunction
    assign rdata = rd_pat(a_addr);
    assign n_rdata = rd_pat(n_addr);

    sbsc_bus_model u_bus (.clk_i(clk), .bus_o(bus), .addr_o(addr), .data_o(dq_in));
    sbsc_core #(.WIDE_ORG(1'h1)) u_dut (.REF_CLK_I(clk), .RST_I(rst), .MODE_PINS_I(mode), .BUS_CTRL_I(bus),
        .ADDR_I(addr), .OUT_EN_N_I(oe_n), .DQ_I(dq_in), .DQ_O(dq_out), .DQ_OE_O(dq_oe), .ARRAY_ADDR_O(a_addr),
        .ARRAY_WE_O(we), .ARRAY_WDATA_O(wdata), .ARRAY_RDATA_I(rdata), .STANDBY_O(standby),
        .DRIVE_HIGH_O(drive_high));
    sbsc_core #(.WIDE_ORG(1'h0)) u_dut_narrow (.REF_CLK_I(clk), .RST_I(rst), .MODE_PINS_I(mode),
        .BUS_CTRL_I(bus), .ADDR_I(addr), .OUT_EN_N_I(oe_n), .DQ_I(dq_in), .DQ_O(), .DQ_OE_O(n_oe),
        .ARRAY_ADDR_O(n_addr), .ARRAY_WE_O(n_we), .ARRAY_WDATA_O(), .ARRAY_RDATA_I(n_rdata), .STANDBY_O(),
        .DRIVE_HIGH_O());

    // 200 MHz clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // change mode pins and output enable, then let the synchroniser settle
    task automatic set_mode(input sbsc_mode_t m, input logic oen);
        @(posedge clk);
        mode <= m;
        oe_n <= oen;
        repeat (10) @(posedge clk);
        #1;
    endtask

    // burst of five advances from preset p, order chosen by inter
    task automatic test_burst(input logic inter, input logic [1:0] p, input logic oen);
        sbsc_mode_t m;
        logic [ADDR_W-1:0] a, prev;
        m = MODE_DEFAULT;
        m.burst_order_sel_n = inter;
        set_mode(m, oen);
        a = {17'h1a5c3, p};
        u_bus.cyc(RD_C, a, '0);
        for (int i = 0; i < 5; i++) begin
            prev = a_addr;
            u_bus.cyc(BURST_ADVANCE_N, '0, '0);
            `CHK(a_addr, {a[ADDR_W-1:2], inter ? (p ^ 2'(i)) : 2'(p + 2'(i))})
            if (i > 0) `CHK(dq_oe, oen ? 4'h0 : 4'hf)
            if (i > 0 && !oen) `CHK(dq_out, rd_pat(prev))
        end
        u_bus.cyc(DESEL, '0, '0);
    endtask

    // single read followed by deselects, output slot per mode
    task automatic test_read(input logic flow, input logic dcd);
        sbsc_mode_t m;
        logic [ADDR_W-1:0] a;
        m = MODE_DEFAULT;
        m.flow_through_sel_n = ~flow;
        m.deselect_mode_sel = ~dcd;
        // a fresh address per run so stale output data never matches
        a = {16'h5a3c, 1'h1, flow, dcd};
        set_mode(m, 1'h0);
        u_bus.cyc(RD_C, a, '0);
        u_bus.cyc(DESEL, '0, '0);
        `CHK(dq_oe, flow ? 4'hf : 4'h0)
        if (flow) `CHK(dq_out, rd_pat(a))
        u_bus.cyc(DESEL, '0, '0);
        `CHK(dq_oe, flow ? 4'h0 : 4'hf)
        `CHK(n_oe, flow ? 4'h0 : 4'h3)
        if (!flow) `CHK(dq_out, rd_pat(a))
        u_bus.cyc(DESEL, '0, '0);
        `CHK(dq_oe, (dcd && !flow) ? 4'hf : 4'h0)
    endtask

    // back-to-back writes: global first, then lane combinations
    task automatic test_write();
        sbsc_bus_t b;
        logic [LANES-1:0] e;
        for (int k = 0; k < 9; k++) begin
            b = (k == 8) ? DESEL : sbsc_bus_t'{1'h0, 1'h1, 1'h0, 1'h1, k > 0, 1'h0, LANE_TBL[k % 8]};
            u_bus.cyc(b, 19'h0_0100 + 19'(k), 36'h3_c0de_0000 + 36'(k));
            if (k > 0) begin
                e = (k == 1) ? 4'hf : ~LANE_TBL[k-1];
                `CHK(we, e)
                `CHK(n_we, e & LANES_NARROW)
                `CHK(wdata, 36'h3_c0de_0000 + 36'(k - 1))
                `CHK(dq_oe, 4'h0)
            end
        end
    endtask

    // chip select high blocks a start; proc strobe start always reads
    task automatic test_select();
        u_bus.cyc(RD_C, 19'h2_1234, '0);
        u_bus.cyc('{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 4'h0}, 19'h7_0001, 36'h5);
        `CHK(a_addr, 19'h2_1234)
        u_bus.cyc('{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 4'hf}, 19'h3_0bad, 36'h9);
        `CHK(we, 4'h0)
        `CHK(a_addr, 19'h2_1234)
        u_bus.cyc(DESEL, '0, '0);
        `CHK(a_addr, 19'h3_0bad)
        `CHK(we, 4'h0)
    endtask

    // sleep blocks writes; drive select follows its pin
    task automatic test_sleep();
        sbsc_mode_t m;
        m = MODE_DEFAULT;
        m.sleep_req = 1'h1;
        m.drive_strength_sel = 1'h0;
        set_mode(m, 1'h0);
        `CHK(standby, 1'h1)
        `CHK(drive_high, 1'h1)
        u_bus.cyc('{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 4'hf}, 19'h1_1111, 36'h7);
        u_bus.cyc(DESEL, '0, '0);
        `CHK(we, 4'h0)
        set_mode(MODE_DEFAULT, 1'h0);
        `CHK(standby, 1'h0)
    endtask

    // verdict and end of run
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    // main sequence
    initial begin
        rst = 1'h1;
        oe_n = 1'h1;
        mode = MODE_DEFAULT;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        set_mode(MODE_DEFAULT, 1'h0);
        `CHK(drive_high, 1'h0)
        `CHK(standby, 1'h0)
        test_burst(1'h1, 2'h1, 1'h0);
        test_burst(1'h0, 2'h2, 1'h1);
        test_burst(1'h0, 2'h3, 1'h0);
        test_read(1'h0, 1'h0);
        test_read(1'h0, 1'h1);
        test_read(1'h1, 1'h0);
        test_write();
        test_select();
        test_sleep();
        finish_test();
    end
endmodule // test_sync_burst_sram_control
